// file: verilog/sadc_top.sv
`timescale 1ns/100ps
// What this block does
// [RULE1] Upper nibble chan_sel picks one of eight analog inputs.
// [RULE2] chan_sel accepted with sw_start write; software avoids changing it while busy.
// [RULE3] done_flag sets at every conversion end regardless of done_irq_en.
// [RULE4] Interrupt request is done_flag AND done_irq_en.
// [RULE5] Writing 0 clears done_flag; writing 1 changes nothing.
// [RULE6] Read-modify-write reads of done_flag return 1.
// [RULE7] conv_busy is 1 during conversion, read-only.
// [RULE8] ref_switch_on drives the reference supply switch.
// [RULE9] Writing 1 to sw_start starts conversion when auto_trigger_en is 0.
// [RULE10] Writing 0 never stops conversion; sw_start reads 0.
// [RULE11] sw_start writes ignored while auto_trigger_en is 1.
// [RULE12] sw_start during conversion restarts it from the beginning.
// [RULE13] conv_clk_div divides machine clock by 1, 2, 4 or 8.
// [RULE14] sample_len_sel gives 4, 7, 10 or 16 conv_clk sampling periods.
// [RULE15] Auto mode starts on each rising edge of the selected trigger.
// [RULE16] hw_trigger_sel 0 means no source, 1 means timer_out0.
// [RULE17] Eight-bit mode puts 8 bits in result_low, zeroes result_high.
// [RULE18] Ten-bit result: two MSBs in result_high bits 1:0.
// [RULE19] Result registers read-only; upper six bits of result_high read 0.
// [RULE20] Result registers keep old value until new result final.
// [RULE21] Software changes format, timing and divider only while stopped.
// [RULE22] Software reads results and clears done_flag before next completion.
// [RULE23] At end: load results, then clear busy and set done_flag.
// [RULE24] Stop, watch or reset mode halts conversion and clears busy.
// [RULE25] Restart coinciding with completion still sets done_flag.
// [RULE26] Compare lasts 10 conv_clk periods plus one machine clock.
// [RULE27] Trial code goes out; one comparator bit sampled per conv_clk.
// [RULE28] All four registers reset to zero.
module sadc_top
  import sadc_pkg::*;
(
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RST_N_I,
  // Register port
  input wire logic [7:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic RMW_I,
  output logic [7:0] RDATA_O,
  // Power mode
  input wire logic HALT_MODE_I,
  // Trigger from timer
  input wire logic TIMER_OUT0_I,
  // Analog front end
  output sadc_pkg::sadc_ana_t ANA_O,
  input wire logic CMP_I,
  output logic REF_SWITCH_ON_O,
  // Interrupt request
  output logic IRQ_O
);
  import sadc_pkg::*;

  sadc_bus_req_t req;
  logic [7:0] ctrl_r;
  logic [7:0] cfg_r;
  logic [7:0] res_hi_r;
  logic [7:0] res_lo_r;
  logic done_r;
  sadc_state_t state_r;
  logic [2:0] div_cnt_r;
  logic [4:0] phase_cnt_r;
  logic [9:0] sar_r;
  logic [9:0] bit_mask_r;
  logic [2:0] tmr_sync_r;
  logic tmr_level_r;
  logic [7:0] rdata_r;
  logic cclk_en;
  logic sw_start;
  logic hw_start;
  logic start;
  logic finish;
  logic [4:0] slen;
  logic [9:0] trial;
  logic busy;

  function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] ofs);
    reg_hit = (a == ofs);
  endfunction : reg_hit

  assign req = '{addr: ADDR_I, wdata: WDATA_I, wr: WR_I, rd: RD_I, rmw: RMW_I};

  // Prescaler enable for conv_clk
  always_comb
  begin
    case (cfg_r[SADC_DIV_MSB:SADC_DIV_LSB])
      2'b00: cclk_en = 1'b1; // [RULE13]
      2'b01: cclk_en = (div_cnt_r[0] == 1'b1);
      2'b10: cclk_en = (div_cnt_r[1:0] == 2'b11);
      default: cclk_en = (div_cnt_r == 3'h7);
    endcase
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
      div_cnt_r <= 3'h0;
    else
      div_cnt_r <= div_cnt_r + 3'h1;
  end

  always_comb
  begin
    case (cfg_r[SADC_SLEN_MSB:SADC_SLEN_LSB])
      2'b00: slen = SADC_SLEN_0; // [RULE14]
      2'b01: slen = SADC_SLEN_1;
      2'b10: slen = SADC_SLEN_2;
      default: slen = SADC_SLEN_3;
    endcase
  end

  // Timer pin crosses in; edge judged only on the agreeing later stages
  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
    begin
      tmr_sync_r <= 3'h0;
      tmr_level_r <= 1'b0;
    end
    else
    begin
      tmr_sync_r <= {tmr_sync_r[1:0], TIMER_OUT0_I};
      if (tmr_sync_r[1] == tmr_sync_r[2])
        tmr_level_r <= tmr_sync_r[2];
    end
  end

  // Only the timer source exists; select 0 gives no start
  assign hw_start = cfg_r[SADC_AUTO_BIT] && cfg_r[SADC_HWSEL_BIT] // [RULE15] [RULE16]
                    && (tmr_sync_r[1] == tmr_sync_r[2]) && tmr_sync_r[2] && !tmr_level_r;
  assign sw_start = req.wr && reg_hit(req.addr, SADC_CTRL_OFS)
                    && req.wdata[SADC_START_BIT] && !cfg_r[SADC_AUTO_BIT]; // [RULE9] [RULE11]
  assign start = (sw_start || hw_start) && !HALT_MODE_I;
  assign finish = (state_r == SADC_FINAL);
  assign trial = sar_r | bit_mask_r;
  assign busy = (state_r != SADC_IDLE); // [RULE7]

  // Conversion sequencer
  // Halt outranks start, so a wake never resumes a stale conversion
  // A restart drops the partial code; the old result stays readable
  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I || HALT_MODE_I)
    begin
      state_r <= SADC_IDLE; // [RULE24]
      phase_cnt_r <= 5'h0;
      sar_r <= 10'h000;
      bit_mask_r <= 10'h000;
    end
    else if (start)
    begin
      state_r <= SADC_SAMPLE; // [RULE12]
      phase_cnt_r <= 5'h0;
      sar_r <= 10'h000;
      bit_mask_r <= 10'h200;
    end
    else
    begin
      case (state_r)
        SADC_IDLE: ;
        SADC_SAMPLE:
          if (cclk_en)
          begin
            if (phase_cnt_r == slen - 5'h1)
            begin
              state_r <= SADC_COMPARE;
              phase_cnt_r <= 5'h0;
            end
            else
              phase_cnt_r <= phase_cnt_r + 5'h1;
          end
        SADC_COMPARE:
          if (cclk_en)
          begin
            if (CMP_I)
              sar_r <= trial; // [RULE27]
            bit_mask_r <= bit_mask_r >> 1;
            if (phase_cnt_r == 5'(SADC_CMP_BITS) - 5'h1)
              state_r <= SADC_FINAL; // [RULE26]
            else
              phase_cnt_r <= phase_cnt_r + 5'h1;
          end
        SADC_FINAL:
          state_r <= SADC_IDLE;
        default:
          state_r <= SADC_IDLE;
      endcase
    end
  end

  // Results move only at the final cycle
  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
    begin
      res_hi_r <= SADC_REG_RST; // [RULE28]
      res_lo_r <= SADC_REG_RST;
    end
    else if (finish)
    begin
      if (cfg_r[SADC_EIGHT_BIT])
      begin
        res_hi_r <= 8'h00; // [RULE17]
        res_lo_r <= sar_r[9:2];
      end
      else
      begin
        res_hi_r <= {6'h00, sar_r[9:8]}; // [RULE18] [RULE20] [RULE23]
        res_lo_r <= sar_r[7:0];
      end
    end
  end

  // Control registers; bus writes to results are dropped
  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
    begin
      ctrl_r <= SADC_REG_RST;
      cfg_r <= SADC_REG_RST;
    end
    else if (req.wr)
    begin
      if (reg_hit(req.addr, SADC_CTRL_OFS))
        ctrl_r <= {req.wdata[7:4], 4'h0}; // [RULE1] [RULE2] [RULE8] [RULE10] [RULE19]
      if (reg_hit(req.addr, SADC_CFG_OFS))
        cfg_r <= req.wdata;
    end
  end

  // Set wins over the software clear
  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
      done_r <= 1'b0;
    else if (finish)
      done_r <= 1'b1; // [RULE3] [RULE25]
    else if (req.wr && reg_hit(req.addr, SADC_CTRL_OFS) && !req.wdata[SADC_DONE_BIT])
      done_r <= 1'b0; // [RULE5]
  end

  // Reference switch bit kept separately from the channel nibble
  logic refsw_r;
  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
      refsw_r <= 1'b0;
    else if (req.wr && reg_hit(req.addr, SADC_CTRL_OFS))
      refsw_r <= req.wdata[SADC_REFSW_BIT]; // [RULE8]
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
      rdata_r <= 8'h00;
    else if (req.rd)
    begin
      if (reg_hit(req.addr, SADC_CTRL_OFS))
        rdata_r <= {ctrl_r[7:4], done_r | req.rmw, state_r != SADC_IDLE, refsw_r, 1'b0}; // [RULE6] [RULE7] [RULE10]
      else if (reg_hit(req.addr, SADC_CFG_OFS))
        rdata_r <= cfg_r;
      else if (reg_hit(req.addr, SADC_RESH_OFS))
        rdata_r <= {6'h00, res_hi_r[1:0]}; // [RULE19]
      else if (reg_hit(req.addr, SADC_RESL_OFS))
        rdata_r <= res_lo_r;
      else
        rdata_r <= 8'h00;
    end
    else
      rdata_r <= 8'h00;
  end

  assign RDATA_O = rdata_r;
  assign IRQ_O = done_r && cfg_r[SADC_IRQEN_BIT]; // [RULE4]
  assign REF_SWITCH_ON_O = refsw_r;
  assign ANA_O = '{trial: trial, sample: (state_r == SADC_SAMPLE), chan: ctrl_r[6:4]}; // [RULE1]

  a_done_on_finish: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // [RULE3]
    finish |=> done_r)
    else $error("done flag not set after completion");
  a_irq_follows: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // [RULE4]
    IRQ_O == (done_r && cfg_r[3]))
    else $error("irq mismatch");
  a_clear_zero: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // [RULE5]
    (WR_I && ADDR_I == 8'h6c && !WDATA_I[3] && !finish) |=> !done_r)
    else $error("done not cleared");
  a_write_one_keep: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // [RULE5]
    (done_r && WR_I && ADDR_I == 8'h6c && WDATA_I[3]) |=> done_r)
    else $error("done lost on write 1");
  a_rmw_reads_one: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // [RULE6]
    (RD_I && RMW_I && ADDR_I == 8'h6c) |=> RDATA_O[3])
    else $error("rmw read of done not 1");
  a_start_reads_zero: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // [RULE10]
    (RD_I && ADDR_I == 8'h6c) |=> !RDATA_O[0])
    else $error("start bit read nonzero");
  a_auto_blocks_sw: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // [RULE11]
    (state_r == SADC_IDLE && cfg_r[2] && !hw_start) |=> state_r == SADC_IDLE)
    else $error("conversion started in auto mode without trigger");
  a_sw_restart: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // [RULE12]
    (sw_start && !HALT_MODE_I) |=> (state_r == SADC_SAMPLE && phase_cnt_r == 5'h0))
    else $error("software start did not restart");
  a_results_hold: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // [RULE20]
    !finish |=> $stable(res_lo_r) && $stable(res_hi_r))
    else $error("results changed mid conversion");
  a_halt_stops: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // [RULE24]
    HALT_MODE_I |=> state_r == SADC_IDLE)
    else $error("halt did not stop conversion");
  a_eight_bit_hi: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // [RULE17]
    (finish && cfg_r[7]) |=> res_hi_r == 8'h00)
    else $error("high result nonzero in 8-bit mode");
  c_full_conv: cover property (@(posedge CLK_I) disable iff (!RST_N_I) finish);
  c_restart: cover property (@(posedge CLK_I) disable iff (!RST_N_I)
    sw_start && state_r == SADC_COMPARE);
  c_hw_start: cover property (@(posedge CLK_I) disable iff (!RST_N_I) hw_start);
  c_eight_bit: cover property (@(posedge CLK_I) disable iff (!RST_N_I)
    finish && cfg_r[7]);
  c_restart_finish: cover property (@(posedge CLK_I) disable iff (!RST_N_I)
    finish && sw_start);

  // Register port checks
  a_ref_on: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // [RULE8]
    (WR_I && ADDR_I == 8'h6c && WDATA_I[1]) |=> REF_SWITCH_ON_O)
    else $error("reference switch not driven on");
  a_chan_route: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // [RULE1]
    (WR_I && ADDR_I == 8'h6c && WDATA_I[4]) |=> ANA_O.chan[0])
    else $error("channel select not routed");
  a_busy_read: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // [RULE7]
    (RD_I && ADDR_I == 8'h6c && busy) |=> RDATA_O[2])
    else $error("busy not read during conversion");
  a_resl_readonly: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // [RULE19]
    (WR_I && ADDR_I == 8'h6f && !finish) |=> $stable(res_lo_r))
    else $error("low result changed by a write");
  a_hi_upper_zero: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // [RULE19]
    res_hi_r[7:2] == 6'h00)
    else $error("upper result bits nonzero");

  // Start sources and clock divider
  a_sw_starts: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // [RULE9]
    (WR_I && ADDR_I == 8'h6c && WDATA_I[0] && !cfg_r[2] && !HALT_MODE_I) |=> busy)
    else $error("software start ignored");
  a_write_zero_start: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // [RULE10]
    (WR_I && ADDR_I == 8'h6c && !WDATA_I[0] && busy && !finish && !HALT_MODE_I) |=> busy)
    else $error("write of zero stopped conversion");
  a_hw_start_auto: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // [RULE15]
    (hw_start && !HALT_MODE_I) |=> (state_r == SADC_SAMPLE && phase_cnt_r == 5'h0))
    else $error("trigger edge did not start");
  a_no_source: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // [RULE16]
    !cfg_r[4] |-> !hw_start)
    else $error("start without a source");
  a_div_by_one: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // [RULE13]
    (cfg_r[1:0] == 2'b00) |-> cclk_en)
    else $error("undivided conversion clock missing");

  // Conversion end
  a_done_irq_off: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // [RULE3]
    (finish && !cfg_r[3]) |=> done_r)
    else $error("done not set with irq disabled");
  a_cmp_len: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // [RULE26]
    (state_r == SADC_COMPARE && cclk_en && phase_cnt_r == 5'd9 && !start && !HALT_MODE_I)
    |=> finish)
    else $error("compare phase length wrong");
  a_busy_clear_done: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // [RULE23]
    (finish && !start && !HALT_MODE_I) |=> (!busy && done_r))
    else $error("end of conversion order wrong");

  // Reset values; no disable here on purpose
  a_reset_zero: assert property (@(posedge CLK_I) // [RULE28]
    !RST_N_I |=> (ctrl_r == 8'h00 && cfg_r == 8'h00 && res_hi_r == 8'h00 && res_lo_r == 8'h00))
    else $error("registers not zero after reset");

endmodule : sadc_top

// file: verilog/sadc_pkg.sv
package sadc_pkg;

  // Register offsets
  localparam logic [7:0] SADC_CTRL_OFS = 8'h6c;
  localparam logic [7:0] SADC_CFG_OFS = 8'h6d;
  localparam logic [7:0] SADC_RESH_OFS = 8'h6e;
  localparam logic [7:0] SADC_RESL_OFS = 8'h6f;
  localparam logic [7:0] SADC_REG_RST = 8'h00;

  // conv_ctrl_status_reg fields
  localparam int SADC_CHAN_MSB = 7;
  localparam int SADC_CHAN_LSB = 4;
  localparam int SADC_DONE_BIT = 3;
  localparam int SADC_BUSY_BIT = 2;
  localparam int SADC_REFSW_BIT = 1;
  localparam int SADC_START_BIT = 0;

  // conv_config_reg fields
  localparam int SADC_EIGHT_BIT = 7;
  localparam int SADC_SLEN_MSB = 6;
  localparam int SADC_SLEN_LSB = 5;
  localparam int SADC_HWSEL_BIT = 4;
  localparam int SADC_IRQEN_BIT = 3;
  localparam int SADC_AUTO_BIT = 2;
  localparam int SADC_DIV_MSB = 1;
  localparam int SADC_DIV_LSB = 0;

  // Sampling lengths in conv_clk periods
  localparam logic [4:0] SADC_SLEN_0 = 5'd4;
  localparam logic [4:0] SADC_SLEN_1 = 5'd7;
  localparam logic [4:0] SADC_SLEN_2 = 5'd10;
  localparam logic [4:0] SADC_SLEN_3 = 5'd16;

  // Compare phase: one bit per conv_clk period
  localparam logic [3:0] SADC_CMP_BITS = 4'd10;

  typedef enum logic [1:0] {SADC_IDLE, SADC_SAMPLE, SADC_COMPARE, SADC_FINAL} sadc_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic rmw;
  } sadc_bus_req_t;

  typedef struct packed {
    logic [9:0] trial;
    logic sample;
    logic [2:0] chan;
  } sadc_ana_t;

endpackage : sadc_pkg

// file: verif/test_sadc_top.sv
`timescale 1ns/100ps
module test_sadc_top;
  import sadc_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic rmw_i = 1'b0;
  logic halt_i = 1'b0;
  logic timer_i = 1'b0;
  logic [7:0] rdata_o;
  sadc_ana_t ana_o;
  logic ref_o;
  logic irq_o;
  logic [9:0] target = 10'h000;
  logic cmp_i;
  logic [31:0] lfsr_r = 32'h05a9;
  logic [7:0] rv;
  logic [7:0] cfg;
  int num_errors = 0;
  int checks_done = 0;
  int samp_cnt = 0;
  int n;

  // Ideal comparator; combinational so that a divide-by-1 clock sees each trial
  assign cmp_i = (ana_o.trial <= target);
  always #10 clk_i = ~clk_i;
  always @(posedge clk_i)
    if (ana_o.sample === 1'b1)
      samp_cnt++;

  sadc_top DUT (.CLK_I(clk_i), .RST_N_I(rst_n_i), .ADDR_I(addr_i), .WDATA_I(wdata_i),
    .WR_I(wr_i), .RD_I(rd_i), .RMW_I(rmw_i), .RDATA_O(rdata_o), .HALT_MODE_I(halt_i),
    .TIMER_OUT0_I(timer_i), .ANA_O(ana_o), .CMP_I(cmp_i), .REF_SWITCH_ON_O(ref_o),
    .IRQ_O(irq_o));

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  function automatic logic [7:0] exp_high(input logic [9:0] t, input logic e8);
    return e8 ? 8'h00 : {6'h00, t[9:8]};
  endfunction : exp_high
  function automatic logic [7:0] exp_low(input logic [9:0] t, input logic e8);
    return e8 ? t[9:2] : t[7:0];
  endfunction : exp_low
  function automatic int slen_of(input logic [1:0] s);
    return (s == 2'b00) ? 4 : (s == 2'b01) ? 7 : (s == 2'b10) ? 10 : 16;
  endfunction : slen_of

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    checks_done++;
    if (seen !== want)
    begin
      num_errors++;
      $display("BAD at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic m, output logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    rmw_i <= m;
    @(posedge clk_i);
    rd_i <= 1'b0;
    rmw_i <= 1'b0;
    #1 d = rdata_o;
  endtask : rd
  task automatic rdchk(input logic [7:0] a, input logic [7:0] mask, input logic [7:0] want);
    rd(a, 1'b0, rv);
    check(rv & mask, want);
  endtask : rdchk
  task automatic wait_idle;
    n = 0;
    rv = 8'h04;
    while (rv[SADC_BUSY_BIT] !== 1'b0 && n < 200)
    begin
      rd(SADC_CTRL_OFS, 1'b0, rv);
      n++;
    end
    if (n >= 200)
      num_errors++;
  endtask : wait_idle
  task automatic results(input logic [9:0] t, input logic e8);
    rdchk(SADC_RESH_OFS, 8'hff, exp_high(t, e8));
    rdchk(SADC_RESL_OFS, 8'hff, exp_low(t, e8));
  endtask : results
  task automatic tally_and_finish;
    if (num_errors == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    #400000;
    num_errors++;
    tally_and_finish();
  end

  initial
  begin
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    for (int a = 8'h6c; a <= 8'h70; a++)
      rdchk(a[7:0], 8'hff, SADC_REG_RST);
    @(posedge clk_i);
    target <= 10'h2b5;
    wr(SADC_CTRL_OFS, 8'h53);
    rdchk(SADC_CTRL_OFS, 8'h05, 8'h04);
    check({7'h00, ref_o}, 8'h01);
    check({5'h00, ana_o.chan}, 8'h05);
    rdchk(SADC_RESL_OFS, 8'hff, 8'h00);
    wr(SADC_CTRL_OFS, 8'h52);
    rdchk(SADC_CTRL_OFS, 8'h04, 8'h04);
    wait_idle();
    rdchk(SADC_CTRL_OFS, 8'h0c, 8'h08);
    check({7'h00, irq_o}, 8'h00);
    wr(SADC_RESH_OFS, 8'hff);
    wr(SADC_RESL_OFS, 8'h00);
    results(10'h2b5, 1'b0);
    wr(SADC_CFG_OFS, 8'h08);
    #1 check({7'h00, irq_o}, 8'h01);
    wr(SADC_CTRL_OFS, 8'h5a);
    rdchk(SADC_CTRL_OFS, 8'hfb, 8'h5a);
    wr(SADC_CTRL_OFS, 8'h52);
    #1 check({7'h00, irq_o}, 8'h00);
    rdchk(SADC_CTRL_OFS, 8'h08, 8'h00);
    rd(SADC_CTRL_OFS, 1'b1, rv);
    check(rv & 8'h08, 8'h08);
    // Random targets over every divider and sampling length
    for (int k = 0; k < 16; k++)
    begin
      lfsr_r = lfsr_next(lfsr_r);
      cfg = {lfsr_r[0], k[1:0], 3'b000, k[3:2]};
      @(posedge clk_i);
      target <= lfsr_r[17:8];
      wr(SADC_CFG_OFS, cfg);
      samp_cnt = 0;
      wr(SADC_CTRL_OFS, 8'h03);
      wait_idle();
      n = slen_of(k[1:0]) * (1 << k[3:2]);
      check({7'h00, samp_cnt >= n - (1 << k[3:2]) && samp_cnt <= n + 1}, 8'h01);
      results(lfsr_r[17:8], lfsr_r[0]);
      wr(SADC_CTRL_OFS, 8'h00);
    end
    // Restart in the compare phase with a new channel
    @(posedge clk_i);
    target <= 10'h155;
    wr(SADC_CFG_OFS, 8'h63);
    wr(SADC_CTRL_OFS, 8'h01);
    repeat (150) @(posedge clk_i);
    target <= 10'h3ca;
    wr(SADC_CTRL_OFS, 8'h33);
    #1 check({5'h00, ana_o.chan}, 8'h03);
    repeat (100) @(posedge clk_i);
    rdchk(SADC_CTRL_OFS, 8'h04, 8'h04);
    wait_idle();
    results(10'h3ca, 1'b0);
    // Auto mode start: no source, then timer source
    wr(SADC_CTRL_OFS, 8'h00);
    wr(SADC_CFG_OFS, 8'h04);
    timer_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    timer_i <= 1'b0;
    wr(SADC_CTRL_OFS, 8'h01);
    rdchk(SADC_CTRL_OFS, 8'h0c, 8'h00);
    wr(SADC_CFG_OFS, 8'h14);
    wr(SADC_CTRL_OFS, 8'h01);
    rdchk(SADC_CTRL_OFS, 8'h04, 8'h00);
    target <= 10'h0e7;
    timer_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    rdchk(SADC_CTRL_OFS, 8'h04, 8'h04);
    wait_idle();
    timer_i <= 1'b0;
    results(10'h0e7, 1'b0);
    // Stop mode in mid conversion
    wr(SADC_CFG_OFS, 8'h00);
    wr(SADC_CTRL_OFS, 8'h01);
    halt_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rdchk(SADC_CTRL_OFS, 8'h04, 8'h00);
    wr(SADC_CTRL_OFS, 8'h01);
    rdchk(SADC_CTRL_OFS, 8'h04, 8'h00);
    halt_i <= 1'b0;
    tally_and_finish();
  end
endmodule : test_sadc_top
